// ===== hdl/rmp_postproc.sv
// Reading math post-processor: operation select, pairing check, datapath, statistics
// How it works
// RULE1 - Five operations exist and only the one held in the operation register can be active.
// RULE2 - While enabled, the operation transforms, flags (limit test) or accumulates every reading that arrives.
// RULE3 - Math stays on until the host turns it off, the function changes, or reset occurs.
// RULE4 - Reference, offset and limit registers are preset by the host; result registers hold output.
// RULE5 - Average and limit pair with all nine functions, null with all but ratio, decibel ops with voltage.
// RULE6 - Selecting an operation not allowed with the current function turns math off.
// RULE7 - Switching from a valid active operation to an invalid one raises a settings conflict.
// RULE8 - The host enables math before writing the null offset or decibel reference.
// RULE9 - The mean of readings since averaging was enabled is held and cleared on enable and reset.
// RULE10 - The reading count since averaging was enabled is held and cleared on enable and reset.
// RULE11 - Largest and smallest readings are tracked and cleared on enable and reset.
// RULE12 - Limit test flags each reading that lies above the upper or below the lower limit.
// RULE13 - Null offset outputs each reading minus the null register.
// RULE14 - With math off readings pass unchanged and statistics stay untouched.
`timescale 1ns/100ps
module rmp_postproc #(
  parameter int DATA_W  = rmp_pkg::RMP_DATA_W,
  parameter int COUNT_W = rmp_pkg::RMP_COUNT_W
) (
  // Clock, reset, enable
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  // Measurement front end
  input  wire rmp_pkg::rmp_func_t   func_i,
  input  wire logic                 rd_valid_i,
  input  wire logic signed [DATA_W-1:0] rd_value_i,
  input  wire logic signed [DATA_W-1:0] rd_power_i,
  // Host commands
  input  wire logic                 cmd_valid_i,
  input  wire rmp_pkg::rmp_cmd_t    cmd_code_i,
  input  wire rmp_pkg::rmp_op_t     cmd_op_i,
  input  wire logic                 cmd_state_i,
  input  wire logic signed [DATA_W-1:0] cmd_value_i,
  // Processed readings
  output logic                      out_valid_o,
  output logic signed [DATA_W-1:0]  out_value_o,
  output logic                      out_fail_o,
  // Status
  output logic                      math_on_o,
  output rmp_pkg::rmp_op_t          math_op_o,
  output logic                      conflict_o,
  // Statistics
  output logic signed [DATA_W-1:0]  avg_mean_o,
  output logic [COUNT_W-1:0]        avg_count_o,
  output logic signed [DATA_W-1:0]  avg_max_o,
  output logic signed [DATA_W-1:0]  avg_min_o
);

  localparam int SUM_W = DATA_W + COUNT_W;

  rmp_pkg::rmp_func_t        func_q;
  logic signed [DATA_W-1:0]  decibel_ref_q;
  logic signed [DATA_W-1:0]  power_ref_q;
  logic signed [DATA_W-1:0]  lower_q;
  logic signed [DATA_W-1:0]  upper_q;
  logic signed [DATA_W-1:0]  null_q;
  logic signed [SUM_W-1:0]   sum_q;
  logic                      dirty_q;
  logic                      neg_q;
  logic                      func_chg;
  logic                      sel_cmd;
  logic                      state_cmd;
  logic                      avg_arm;
  logic                      avg_acc;
  logic                      div_busy;
  logic                      div_done;
  logic                      div_start;
  logic [SUM_W-1:0]          div_num;
  logic [SUM_W-1:0]          div_quo;

  assign func_chg  = (func_i != func_q);
  assign sel_cmd   = cmd_valid_i && (cmd_code_i == rmp_pkg::cmd_select_op) && !func_chg;
  assign state_cmd = cmd_valid_i && (cmd_code_i == rmp_pkg::cmd_set_state) && !func_chg;
  // Averaging freshly enabled
  assign avg_arm = (sel_cmd && math_on_o && cmd_op_i == rmp_pkg::op_running_average
                    && math_op_o != rmp_pkg::op_running_average)
                || (state_cmd && cmd_state_i && !math_on_o
                    && math_op_o == rmp_pkg::op_running_average);
  assign avg_acc = rd_valid_i && math_on_o && math_op_o == rmp_pkg::op_running_average;
  assign div_start = dirty_q && !div_busy && (avg_count_o != '0);
  assign div_num = sum_q[SUM_W-1] ? SUM_W'(-sum_q) : SUM_W'(sum_q);

  // Function tracking
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      func_q <= rmp_pkg::RMP_RESET_FUNC;
    end else if (ce_i) begin
      func_q <= func_i;
    end
  end

  // Operation select and enable
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      math_on_o  <= rmp_pkg::RMP_RESET_ON;
      math_op_o  <= rmp_pkg::RMP_RESET_OP;
      conflict_o <= 1'b0;
    end else if (ce_i) begin
      conflict_o <= 1'b0;
      if (func_chg) begin
        math_on_o <= 1'b0; // RULE3
      end else if (sel_cmd) begin
        math_op_o <= cmd_op_i; // RULE1
        if (!rmp_pkg::rmp_pair_ok(cmd_op_i, func_q)) begin // RULE5
          math_on_o <= 1'b0; // RULE6
          if (math_on_o && rmp_pkg::rmp_pair_ok(math_op_o, func_q)) begin
            conflict_o <= 1'b1; // RULE7
          end
        end
      end else if (state_cmd) begin
        math_on_o <= cmd_state_i && rmp_pkg::rmp_pair_ok(math_op_o, func_q); // RULE5
      end
    end
  end

  // Preset registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      decibel_ref_q <= '0;
      power_ref_q   <= '0;
      lower_q       <= '0;
      upper_q       <= '0;
      null_q        <= '0;
    end else if (ce_i && cmd_valid_i) begin
      case (cmd_code_i) // RULE4
        rmp_pkg::cmd_write_decibel_ref: if (math_on_o) decibel_ref_q <= cmd_value_i; // RULE8
        rmp_pkg::cmd_write_null:        if (math_on_o) null_q <= cmd_value_i; // RULE8
        rmp_pkg::cmd_write_power_ref:   power_ref_q <= cmd_value_i;
        rmp_pkg::cmd_write_lower:       lower_q <= cmd_value_i;
        rmp_pkg::cmd_write_upper:       upper_q <= cmd_value_i;
        default: ;
      endcase
    end
  end

  // Reading datapath
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_value_o <= '0;
      out_fail_o  <= 1'b0;
    end else if (ce_i) begin
      out_valid_o <= rd_valid_i;
      out_fail_o  <= 1'b0;
      if (rd_valid_i) begin
        out_value_o <= rd_value_i; // RULE14
        if (math_on_o) begin // RULE2
          case (math_op_o)
            rmp_pkg::op_null_offset:      out_value_o <= rd_value_i - null_q; // RULE13
            rmp_pkg::power_level_op:      out_value_o <= rd_power_i - power_ref_q;
            rmp_pkg::relative_decibel_op: begin
              out_value_o <= rd_power_i - power_ref_q - decibel_ref_q;
            end
            rmp_pkg::op_limit_test: begin
              out_fail_o <= (rd_value_i > upper_q) || (rd_value_i < lower_q); // RULE12
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Count, sum, extremes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      avg_count_o <= '0;
      sum_q       <= '0;
      avg_max_o   <= '0;
      avg_min_o   <= '0;
      dirty_q     <= 1'b0;
    end else if (ce_i) begin
      if (avg_arm) begin
        avg_count_o <= '0; // RULE10
        sum_q       <= '0;
        avg_max_o   <= '0; // RULE11
        avg_min_o   <= '0; // RULE11
        dirty_q     <= 1'b0;
      end else if (avg_acc) begin
        avg_count_o <= avg_count_o + COUNT_W'(1); // RULE10
        sum_q       <= sum_q + {{COUNT_W{rd_value_i[DATA_W-1]}}, rd_value_i};
        dirty_q     <= 1'b1;
        if (avg_count_o == '0 || rd_value_i > avg_max_o) avg_max_o <= rd_value_i; // RULE11
        if (avg_count_o == '0 || rd_value_i < avg_min_o) avg_min_o <= rd_value_i; // RULE11
      end else if (div_start) begin
        dirty_q <= 1'b0;
      end
    end
  end

  // Mean from the divider
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      avg_mean_o <= '0;
      neg_q      <= 1'b0;
    end else if (ce_i) begin
      if (avg_arm) begin
        avg_mean_o <= '0; // RULE9
      end else begin
        if (div_start) neg_q <= sum_q[SUM_W-1];
        if (div_done) begin
          avg_mean_o <= neg_q ? -div_quo[DATA_W-1:0] : div_quo[DATA_W-1:0]; // RULE9
        end
      end
    end
  end

  rmp_divider #(
    .NUM_W (SUM_W),
    .DEN_W (COUNT_W)
  ) u_div (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .abort_i    (avg_arm),
    .start_i    (div_start),
    .num_i      (div_num),
    .den_i      (avg_count_o),
    .busy_o     (div_busy),
    .done_o     (div_done),
    .quo_o      (div_quo)
  );

  // Checks
  sequence s_bad_switch;
    ce_i && sel_cmd && math_on_o && !rmp_pkg::rmp_pair_ok(cmd_op_i, func_q);
  endsequence

  sequence s_avg_enable;
    ce_i && avg_arm;
  endsequence

  a_pair_legal: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE5
    math_on_o |-> rmp_pkg::rmp_pair_ok(math_op_o, func_q))
    else $error("active operation not allowed with function");

  a_invalid_off: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE6
    ce_i && sel_cmd && !rmp_pkg::rmp_pair_ok(cmd_op_i, func_q) |=> !math_on_o)
    else $error("invalid select left math on");

  a_conflict_flag: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE7
    s_bad_switch |=> conflict_o ##1 (!conflict_o || $past(ce_i) == 1'b0 || $past(conflict_o) == 1'b0))
    else $error("conflict not raised for one cycle");

  a_func_off: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE3
    ce_i && func_chg |=> !math_on_o)
    else $error("function change kept math on");

  a_bypass_off: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE14
    ce_i && rd_valid_i && !math_on_o && !avg_arm |=>
      out_valid_o && out_value_o == $past(rd_value_i) && $stable(avg_count_o))
    else $error("reading altered while math off");

  a_null_sub: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE13
    ce_i && rd_valid_i && math_on_o && math_op_o == rmp_pkg::op_null_offset |=>
      out_value_o == $past(rd_value_i) - $past(null_q))
    else $error("null output wrong");

  a_limit_judge: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE12
    ce_i && rd_valid_i && math_on_o && math_op_o == rmp_pkg::op_limit_test |=>
      out_fail_o == ($past(rd_value_i) > $past(upper_q) || $past(rd_value_i) < $past(lower_q)))
    else $error("limit verdict wrong");

  a_stats_clear: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE10
    s_avg_enable |=> avg_count_o == '0 && avg_max_o == '0 && avg_min_o == '0
      && avg_mean_o == '0)
    else $error("statistics not cleared on enable");

  a_count_step: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE10
    ce_i && avg_acc && !avg_arm |=> avg_count_o == $past(avg_count_o) + COUNT_W'(1))
    else $error("count did not advance");

  a_max_track: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE11
    ce_i && avg_acc && !avg_arm |=> avg_max_o >= $past(rd_value_i) && avg_min_o <= $past(rd_value_i))
    else $error("extremes not tracked");

endmodule // rmp_postproc

// ===== hdl/rmp_pkg.sv
// Constants, types and pairing table for the reading math post-processor
package rmp_pkg;

  localparam int RMP_DATA_W  = 32;
  localparam int RMP_COUNT_W = 32;

  typedef enum logic [2:0] {
    op_running_average,
    relative_decibel_op,
    power_level_op,
    op_limit_test,
    op_null_offset
  } rmp_op_t;

  typedef enum logic [3:0] {
    dc_voltage_function,
    ac_voltage_function,
    dc_current_function,
    ac_current_function,
    two_wire_resistance_function,
    four_wire_resistance_function,
    frequency_function,
    period_function,
    ratio_function
  } rmp_func_t;

  typedef enum logic [2:0] {
    cmd_select_op,
    cmd_set_state,
    cmd_write_decibel_ref,
    cmd_write_power_ref,
    cmd_write_lower,
    cmd_write_upper,
    cmd_write_null
  } rmp_cmd_t;

  // Values after reset
  localparam rmp_op_t   RMP_RESET_OP   = op_null_offset;
  localparam rmp_func_t RMP_RESET_FUNC = dc_voltage_function;
  localparam logic      RMP_RESET_ON   = 1'b0;

  // Operation and function pairing
  function automatic logic rmp_pair_ok(input rmp_op_t op, input rmp_func_t fn);
    logic ok;
    ok = 1'b0;
    case (op)
      op_running_average, op_limit_test: ok = 1'b1;
      op_null_offset:                   ok = (fn != ratio_function);
      relative_decibel_op, power_level_op: begin
        ok = (fn == dc_voltage_function) || (fn == ac_voltage_function);
      end
      default:                          ok = 1'b0;
    endcase
    return ok;
  endfunction

endpackage

// ===== hdl/rmp_divider.sv
// Serial restoring divider for the running mean
`timescale 1ns/100ps
module rmp_divider #(
  parameter int NUM_W = 64,
  parameter int DEN_W = 32
) (
  // Clock and control
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             abort_i,
  // Start strobe and operands
  input  wire logic             start_i,
  input  wire logic [NUM_W-1:0] num_i,
  input  wire logic [DEN_W-1:0] den_i,
  // Result
  output logic                  busy_o,
  output logic                  done_o,
  output logic [NUM_W-1:0]      quo_o
);

  logic [DEN_W-1:0]         rem_q;
  logic [DEN_W-1:0]         den_q;
  logic [$clog2(NUM_W):0]   step_q;
  logic [DEN_W:0]           rem_sh;
  logic [DEN_W:0]           diff;

  assign rem_sh = {rem_q, quo_o[NUM_W-1]};
  assign diff   = rem_sh - {1'b0, den_q};

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      quo_o  <= '0;
      rem_q  <= '0;
      den_q  <= '0;
      step_q <= '0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (abort_i) begin
        busy_o <= 1'b0;
      end else if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        quo_o  <= num_i;
        den_q  <= den_i;
        rem_q  <= '0;
        step_q <= '0;
      end else if (busy_o) begin
        if (!diff[DEN_W]) begin
          rem_q <= diff[DEN_W-1:0];
          quo_o <= {quo_o[NUM_W-2:0], 1'b1};
        end else begin
          rem_q <= rem_sh[DEN_W-1:0];
          quo_o <= {quo_o[NUM_W-2:0], 1'b0};
        end
        step_q <= step_q + 1'b1;
        if (step_q == ($clog2(NUM_W)+1)'(NUM_W - 1)) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule // rmp_divider

// ===== dv/rmp_stim_model.sv
// Front end and host model driving the post-processor inputs
`timescale 1ns/100ps
module rmp_stim_model (
  // Clock
  input  wire logic          core_clk_i,
  // Front end
  output rmp_pkg::rmp_func_t func_o,
  output logic               rd_valid_o,
  output logic signed [31:0] rd_value_o,
  output logic signed [31:0] rd_power_o,
  // Host
  output logic               cmd_valid_o,
  output rmp_pkg::rmp_cmd_t  cmd_code_o,
  output rmp_pkg::rmp_op_t   cmd_op_o,
  output logic               cmd_state_o,
  output logic signed [31:0] cmd_value_o
);
  initial begin
    func_o = rmp_pkg::dc_voltage_function;
    rd_valid_o = 1'b0;
    rd_value_o = 32'h0;
    rd_power_o = 32'h0;
    cmd_valid_o = 1'b0;
    cmd_code_o = rmp_pkg::cmd_select_op;
    cmd_op_o = rmp_pkg::op_null_offset;
    cmd_state_o = 1'b0;
    cmd_value_o = 32'h0;
  end
  // Function change, then one edge so it is taken alone
  task automatic set_func(input rmp_pkg::rmp_func_t f);
    @(posedge core_clk_i);
    func_o <= f;
    @(posedge core_clk_i);
  endtask
  // One command pulse; released data shows the inverse
  task automatic cmd(input rmp_pkg::rmp_cmd_t c, input rmp_pkg::rmp_op_t o,
                     input logic s, input logic signed [31:0] v);
    @(posedge core_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o <= c;
    cmd_op_o <= o;
    cmd_state_o <= s;
    cmd_value_o <= v;
    @(posedge core_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_value_o <= ~v;
  endtask
  // One reading pulse; released data shows the inverse
  task automatic read(input logic signed [31:0] v, input logic signed [31:0] p);
    @(posedge core_clk_i);
    rd_valid_o <= 1'b1;
    rd_value_o <= v;
    rd_power_o <= p;
    @(posedge core_clk_i);
    rd_valid_o <= 1'b0;
    rd_value_o <= ~v;
    rd_power_o <= ~p;
  endtask
endmodule // rmp_stim_model

// ===== dv/reading_math_postprocessor_tb.sv
// Self-checking bench for the reading math post-processor
`timescale 1ns/100ps
module reading_math_postprocessor_tb;
  logic                 core_clk_i;
  logic                 rst_i;
  logic                 ce;
  rmp_pkg::rmp_func_t   func;
  rmp_pkg::rmp_cmd_t    cmd_code;
  rmp_pkg::rmp_op_t     cmd_op;
  rmp_pkg::rmp_op_t     math_op;
  logic                 rd_valid, cmd_valid, cmd_state;
  logic                 out_valid, out_fail, math_on, conflict;
  logic signed [31:0]   rd_value, rd_power, cmd_value, out_value;
  logic signed [31:0]   avg_mean, avg_max, avg_min;
  logic [31:0]          avg_count;
  int                   errors;
  int                   check_count;

  rmp_stim_model m (.core_clk_i(core_clk_i), .func_o(func), .rd_valid_o(rd_valid),
    .rd_value_o(rd_value), .rd_power_o(rd_power), .cmd_valid_o(cmd_valid),
    .cmd_code_o(cmd_code), .cmd_op_o(cmd_op), .cmd_state_o(cmd_state),
    .cmd_value_o(cmd_value));

  rmp_postproc DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce), .func_i(func),
    .rd_valid_i(rd_valid), .rd_value_i(rd_value), .rd_power_i(rd_power),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_op_i(cmd_op),
    .cmd_state_i(cmd_state), .cmd_value_i(cmd_value), .out_valid_o(out_valid),
    .out_value_o(out_value), .out_fail_o(out_fail), .math_on_o(math_on),
    .math_op_o(math_op), .conflict_o(conflict), .avg_mean_o(avg_mean),
    .avg_count_o(avg_count), .avg_max_o(avg_max), .avg_min_o(avg_min));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Command or reading, then settle past the taking edge
  task automatic cm(input rmp_pkg::rmp_cmd_t c, input int v);
    m.cmd(c, rmp_pkg::rmp_op_t'(v[2:0]), v[0], v);
    #1;
  endtask
  task automatic rd(input int v, input int p);
    m.read(v, p);
    #1;
    chk(out_valid, 1);
  endtask

  task automatic t_reset();
    chk(math_on, 0);
    chk(math_op, rmp_pkg::op_null_offset);
    chk(avg_count, 0);
    chk(avg_max, 0);
    chk(avg_mean, 0);
  endtask
  task automatic t_null();
    rd(20, 0);
    chk(out_value, 20);
    cm(rmp_pkg::cmd_write_null, 9);
    cm(rmp_pkg::cmd_set_state, 1);
    rd(20, 0);
    chk(out_value, 20);
    cm(rmp_pkg::cmd_write_null, 7);
    rd(20, 0);
    chk(out_value, 13);
    rd(3, 0);
    chk(out_value, 32'hFFFFFFFC);
  endtask
  task automatic t_freeze();
    @(posedge core_clk_i);
    ce <= 1'b0;
    cm(rmp_pkg::cmd_set_state, 0);
    chk(math_on, 1);
    m.read(50, 0);
    #1;
    chk(out_valid, 0);
    chk(out_value, 32'hFFFFFFFC);
    @(posedge core_clk_i);
    ce <= 1'b1;
  endtask
  task automatic t_limit();
    int v[4] = '{100, 101, -6, -5};
    logic e[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    cm(rmp_pkg::cmd_select_op, rmp_pkg::op_limit_test);
    chk(math_op, rmp_pkg::op_limit_test);
    cm(rmp_pkg::cmd_write_lower, -5);
    cm(rmp_pkg::cmd_write_upper, 100);
    for (int i = 0; i < 4; i++) begin
      rd(v[i], 0);
      chk(out_fail, e[i]);
      chk(out_value, v[i]);
    end
  endtask
  task automatic t_log();
    cm(rmp_pkg::cmd_select_op, rmp_pkg::power_level_op);
    cm(rmp_pkg::cmd_write_power_ref, 3);
    rd(0, 10);
    chk(out_value, 7);
    cm(rmp_pkg::cmd_select_op, rmp_pkg::relative_decibel_op);
    cm(rmp_pkg::cmd_write_decibel_ref, 2);
    rd(0, 10);
    chk(out_value, 5);
  endtask
  task automatic t_avg();
    int i;
    cm(rmp_pkg::cmd_select_op, rmp_pkg::op_running_average);
    rd(10, 0);
    rd(-4, 0);
    rd(30, 0);
    chk(avg_count, 3);
    chk(avg_max, 30);
    chk(avg_min, 32'hFFFFFFFC);
    for (i = 0; i < 200 && avg_mean !== 12; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    chk(avg_mean, 12);
    if (i == 200) begin
      stop_test();
    end
    cm(rmp_pkg::cmd_set_state, 0);
    rd(50, 0);
    chk(out_value, 50);
    chk(avg_count, 3);
    cm(rmp_pkg::cmd_set_state, 1);
    chk(avg_count, 0);
    chk(avg_max, 0);
    chk(avg_mean, 0);
  endtask
  task automatic t_conflict();
    m.set_func(rmp_pkg::dc_current_function);
    #1;
    chk(math_on, 0);
    cm(rmp_pkg::cmd_select_op, rmp_pkg::op_null_offset);
    cm(rmp_pkg::cmd_set_state, 1);
    chk(math_on, 1);
    cm(rmp_pkg::cmd_select_op, rmp_pkg::relative_decibel_op);
    chk(math_on, 0);
    chk(conflict, 1);
    @(posedge core_clk_i);
    #1;
    chk(conflict, 0);
  endtask
  task automatic t_pair();
    logic e;
    for (int f = 0; f < 9; f++) begin
      m.set_func(rmp_pkg::rmp_func_t'(f));
      for (int o = 0; o < 5; o++) begin
        cm(rmp_pkg::cmd_set_state, 0);
        cm(rmp_pkg::cmd_select_op, o);
        chk(conflict, 0);
        cm(rmp_pkg::cmd_set_state, 1);
        e = (o == 0) || (o == 3) || (o == 4 && f != 8) || (o < 3 && f < 2);
        chk(math_on, e);
      end
    end
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  initial begin
    errors = 0;
    check_count = 0;
    rst_i = 1'b1;
    ce = 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    t_reset();
    t_null();
    t_freeze();
    t_limit();
    t_log();
    t_avg();
    t_conflict();
    t_pair();
    stop_test();
  end
endmodule // reading_math_postprocessor_tb
